/* File: verilog/phy_diag_status_control.v */
/*
  Status and diagnostic control of a 10/100 transceiver: management
  registers, interrupt pin, crossover choice, loopback paths, cable test
  and the board connectivity NAND chain.
  Assumes line-side detectors, strap pins and the management pins come
  from outside the clk_sys domain; event, link and carrier inputs are
  produced by logic on clk_sys.
*/
// Contract
// - Optional interrupt pin reports recorded status change
// - Interrupt register upper byte enables conditions
// - Interrupt register lower byte records conditions
// - Reading interrupt register clears status after return
// - Polarity bit selects interrupt level, low default
// - Automatic crossover matches pairs to partner
// - Crossover on at reset, disable bit off
// - Forced pair bit used while crossover off
// - Local loopback returns MAC transmit to receive
// - Nibble variant also transmits on copper
// - Local loopback needs loop, no negotiation, full
// - Remote loopback only at 100 full duplex
// - Start bit launches test, self clears
// - Two-bit result: normal, open, short, invalid
// - Unsilenced partner gives invalid result, no measurement
// - Nine-bit fault distance count presented
// - Pulse sent, reflection timed into distance
// - NAND chain of inputs drives result pin
// - Chain order from management pins to end
// - Registers in 32-entry management space
// - Chain mode by strap or register bit
`timescale 1ns/100ps
`include "phy_diag_regs.vh"

module phy_diag_status_control #(
  parameter TREE_N = 18,
  parameter NIBBLE_MAC = 1,
  parameter [15:0] QUIET_CYC = `QUIET_WAIT_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe,
  input wire [2:0] phy_addr_strap,
  input wire [7:0] int_event,
  output reg interrupt_request_pin,
  input wire pair_rx_on_b,
  output reg pair_crossed,
  input wire link_100_full,
  output reg local_loopback,
  output reg loop_speed_100,
  output reg copper_tx_enable,
  output reg remote_loopback,
  input wire line_energy,
  input wire echo_seen,
  input wire echo_open,
  output wire tdr_pulse,
  output wire silence_req,
  input wire nand_tree_strap,
  input wire [TREE_N-1:0] tree_in,
  input wire carrier_sense,
  output reg tree_result_pin,
  output reg tree_mode
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [15:0] basic_control_q;
  reg [15:0] op_mode_q;
  reg [15:0] int_ctrl_stat_q;
  reg [15:0] phy_control_second_q;
  reg ct_start_q;
  reg [1:0] ct_result_q;
  reg [8:0] ct_distance_q;
  reg ct_launch_q;
  reg [2:0] addr_s1_q;
  reg [2:0] addr_s2_q;
  reg [1:0] pair_s_q;
  reg [1:0] strap_s_q;
  reg [TREE_N-1:0] tree_s1_q;
  reg [TREE_N-1:0] tree_s2_q;
  reg [15:0] rd_data;
  reg [7:0] int_clr;
  wire [4:0] reg_addr;
  wire [15:0] wr_data;
  wire wr_en;
  wire rd_done;
  wire ct_done;
  wire [1:0] ct_result;
  wire [8:0] ct_distance;
  wire [TREE_N-1:0] chain;
  wire irq_any;
  wire tree_sel;

  // Address match used by both write and clear-on-read paths
  function hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ----------------------------------------------------------------
  // Management slave and cable test engine
  // ----------------------------------------------------------------
  mdio_slave u_mdio (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .phy_addr({2'b00, addr_s2_q}),
    .rd_data(rd_data),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_done(rd_done)
  );

  cable_tester #(
    .QUIET_CYC(QUIET_CYC),
    .PULSE_CYC(`TDR_PULSE_CYC),
    .DIST_DIV(`DIST_STEP_CYC)
  ) u_cable (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(ct_launch_q),
    .line_energy(line_energy),
    .echo_seen(echo_seen),
    .echo_open(echo_open),
    .tdr_pulse(tdr_pulse),
    .silence_req(silence_req),
    .done(ct_done),
    .result(ct_result),
    .distance(ct_distance)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Straps are sampled continuously; software sees them settle after reset
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      addr_s1_q <= 3'b000;
      addr_s2_q <= 3'b000;
      pair_s_q <= 2'b00;
      strap_s_q <= 2'b00;
      tree_s1_q <= {TREE_N{1'b0}};
      tree_s2_q <= {TREE_N{1'b0}};
    end else begin
      addr_s1_q <= phy_addr_strap;
      addr_s2_q <= addr_s1_q;
      pair_s_q <= {pair_s_q[0], pair_rx_on_b};
      strap_s_q <= {strap_s_q[0], nand_tree_strap};
      tree_s1_q <= tree_in;
      tree_s2_q <= tree_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Five address bits cover the whole space; unmapped entries read zero
  always @* begin
    rd_data = 16'h0000;
    case (reg_addr)
      `REG_BASIC_CONTROL: rd_data = basic_control_q;
      `REG_OP_MODE: rd_data = op_mode_q;
      `REG_INT_CTRL_STAT: rd_data = int_ctrl_stat_q;
      `REG_CABLE_TEST: rd_data = {ct_start_q, ct_result_q, 4'h0, ct_distance_q};
      `REG_PHY_CONTROL2: rd_data = phy_control_second_q;
      default: rd_data = 16'h0000;
    endcase
  end

  // Status clears only once the last data bit has left the pin
  always @* begin
    int_clr = 8'h00;
    if (rd_done && hit(reg_addr, `REG_INT_CTRL_STAT))
      int_clr = 8'hff;
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      basic_control_q <= `BC_RESET;
      op_mode_q <= `OM_RESET;
      phy_control_second_q <= `C2_RESET;
      int_ctrl_stat_q <= `INT_RESET;
    end else begin
      if (wr_en && hit(reg_addr, `REG_BASIC_CONTROL))
        basic_control_q <= wr_data;
      if (wr_en && hit(reg_addr, `REG_OP_MODE))
        op_mode_q <= wr_data;
      if (wr_en && hit(reg_addr, `REG_PHY_CONTROL2))
        phy_control_second_q <= wr_data;
      if (wr_en && hit(reg_addr, `REG_INT_CTRL_STAT))
        int_ctrl_stat_q[15:8] <= wr_data[15:8];
      // A new event in the clearing cycle survives the clear
      int_ctrl_stat_q[7:0] <= (int_ctrl_stat_q[7:0] & ~int_clr) | int_event;
    end
  end

  // ----------------------------------------------------------------
  // Cable test handshake
  // ----------------------------------------------------------------
  // A start written while a test runs is ignored, not queued
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ct_start_q <= 1'b0;
      ct_launch_q <= 1'b0;
      ct_result_q <= `CT_RES_NORMAL;
      ct_distance_q <= 9'h000;
    end else begin
      ct_launch_q <= 1'b0;
      if (ct_done) begin
        ct_start_q <= 1'b0;
        ct_result_q <= ct_result;
        ct_distance_q <= ct_distance;
      end else if (wr_en && hit(reg_addr, `REG_CABLE_TEST) && wr_data[`CT_START] && !ct_start_q) begin
        ct_start_q <= 1'b1;
        ct_launch_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  assign irq_any = |(int_ctrl_stat_q[15:8] & int_ctrl_stat_q[7:0]);

  // Polarity 0 gives active low, so idle level is high after reset
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      interrupt_request_pin <= 1'b1;
    else
      interrupt_request_pin <= irq_any ^ ~phy_control_second_q[`C2_INT_POL];
  end

  // ----------------------------------------------------------------
  // Crossover and loopback paths
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pair_crossed <= 1'b0;
      local_loopback <= 1'b0;
      loop_speed_100 <= 1'b0;
      copper_tx_enable <= 1'b1;
      remote_loopback <= 1'b0;
    end else begin
      if (!phy_control_second_q[`C2_AUTOX_DIS])
        pair_crossed <= pair_s_q[1];
      else
        pair_crossed <= phy_control_second_q[`C2_MDI_FORCE];
      // Loop only with negotiation off and full duplex
      local_loopback <= basic_control_q[`BC_LOOPBACK] & ~basic_control_q[`BC_ANEG_EN] &
                        basic_control_q[`BC_FULL_DUPLEX];
      loop_speed_100 <= basic_control_q[`BC_SPEED_100];
      // Reduced-pin variant keeps the copper quiet while looping
      copper_tx_enable <= (NIBBLE_MAC != 0) | ~(basic_control_q[`BC_LOOPBACK] &
                          ~basic_control_q[`BC_ANEG_EN] & basic_control_q[`BC_FULL_DUPLEX]);
      // Held off unless the link really is 100 full duplex
      remote_loopback <= phy_control_second_q[`C2_REMOTE_LB] & link_100_full;
    end
  end

  // ----------------------------------------------------------------
  // NAND connectivity chain
  // ----------------------------------------------------------------
  // Index 0 is the first pin walked low and sits deepest in the chain,
  // so each pin pulled low in order flips the end of the chain once.
  assign chain[0] = ~tree_s2_q[0];
  genvar gi;
  generate
    for (gi = 1; gi < TREE_N; gi = gi + 1) begin : g_chain
      assign chain[gi] = ~(tree_s2_q[gi] & chain[gi-1]);
    end
  endgenerate

  assign tree_sel = strap_s_q[1] | op_mode_q[`OM_NAND_TREE];

  // Result pin carries carrier sense outside chain mode
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tree_mode <= 1'b0;
      tree_result_pin <= 1'b0;
    end else begin
      tree_mode <= tree_sel;
      tree_result_pin <= tree_sel ? chain[TREE_N-1] : carrier_sense;
    end
  end

endmodule

/* File: verilog/phy_diag_regs.vh */
/*
  Register map, field positions, reset values and timing counts of the
  transceiver status and diagnostic block.
  Assumes a 25 MHz system clock; included by every design file.
*/
`ifndef PHY_DIAG_REGS_VH
`define PHY_DIAG_REGS_VH

// ----------------------------------------------------------------
// Register indices in the 32-entry management space
// ----------------------------------------------------------------
`define REG_BASIC_CONTROL 5'h00
`define REG_OP_MODE 5'h16
`define REG_INT_CTRL_STAT 5'h1b
`define REG_CABLE_TEST 5'h1d
`define REG_PHY_CONTROL2 5'h1f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BC_LOOPBACK 14
`define BC_SPEED_100 13
`define BC_ANEG_EN 12
`define BC_FULL_DUPLEX 8
`define OM_NAND_TREE 5
`define C2_MDI_FORCE 14
`define C2_AUTOX_DIS 13
`define C2_INT_POL 9
`define C2_REMOTE_LB 2
`define CT_START 15
`define CT_RES_HI 14
`define CT_RES_LO 13
`define CT_DIST_HI 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BC_RESET 16'h3100
`define OM_RESET 16'h0000
`define INT_RESET 16'h0000
`define C2_RESET 16'h0000

// ----------------------------------------------------------------
// Cable test result codes
// ----------------------------------------------------------------
`define CT_RES_NORMAL 2'b00
`define CT_RES_OPEN 2'b01
`define CT_RES_SHORT 2'b10
`define CT_RES_INVALID 2'b11

// ----------------------------------------------------------------
// Management frame and timing counts
// ----------------------------------------------------------------
`define MDIO_PREAMBLE 6'd32
`define MDIO_HDR_BITS 5'd12
`define MDIO_DATA_BITS 5'd16
`define CLK_PERIOD_NS 40
`define TDR_PULSE_NS 100
`define QUIET_WAIT_NS 10000
// Sized for the 16-bit timers; keep in step with the times above
`define TDR_PULSE_CYC 16'd3
`define QUIET_WAIT_CYC 16'd250
`define DIST_STEP_CYC 16'd1

`endif

/* File: verilog/mdio_slave.v */
/*
  Serial management slave: decodes read and write frames on the
  management clock and data pins and exposes a word-wide register port.
  Assumes the management clock is far slower than clk_sys (8 or more
  system clocks per period); both pins are synchronised here.
*/
`timescale 1ns/100ps
`include "phy_diag_regs.vh"

module mdio_slave (
  input wire clk_sys,
  input wire arst_n,
  input wire mdc,
  input wire mdio_in,
  input wire [4:0] phy_addr,
  input wire [15:0] rd_data,
  output reg mdio_out,
  output reg mdio_oe,
  output reg [4:0] reg_addr,
  output reg [15:0] wr_data,
  output reg wr_en,
  output reg rd_done
);

  // ----------------------------------------------------------------
  // Frame states
  // ----------------------------------------------------------------
  localparam S_IDLE = 6'b000001;
  localparam S_START = 6'b000010;
  localparam S_HDR = 6'b000100;
  localparam S_TA = 6'b001000;
  localparam S_RD = 6'b010000;
  localparam S_WR = 6'b100000;

  reg [1:0] mdc_s_q;
  reg [1:0] dat_s_q;
  reg mdc_d_q;
  reg [5:0] st_q;
  reg [5:0] ones_q;
  reg [4:0] cnt_q;
  reg [15:0] sh_q;
  reg is_rd_q;
  wire rise;
  wire bit_in;
  wire [4:0] hdr_phy;
  wire [1:0] hdr_op;

  assign rise = mdc_s_q[1] & ~mdc_d_q;
  assign bit_in = dat_s_q[1];
  assign hdr_op = sh_q[10:9];
  assign hdr_phy = sh_q[8:4];

  // Two-stage synchronisers for the pins
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mdc_s_q <= 2'b00;
      dat_s_q <= 2'b00;
      mdc_d_q <= 1'b0;
    end else begin
      mdc_s_q <= {mdc_s_q[0], mdc};
      dat_s_q <= {dat_s_q[0], mdio_in};
      mdc_d_q <= mdc_s_q[1];
    end
  end

  // Frame walker, one step per management clock rising edge
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE;
      ones_q <= 6'd0;
      cnt_q <= 5'd0;
      sh_q <= 16'h0000;
      is_rd_q <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      reg_addr <= 5'h00;
      wr_data <= 16'h0000;
      wr_en <= 1'b0;
      rd_done <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      rd_done <= 1'b0;
      if (rise) begin
        case (st_q)
          S_IDLE: begin
            if (bit_in) begin
              ones_q <= (ones_q == `MDIO_PREAMBLE) ? ones_q : ones_q + 6'd1;
            end else begin
              ones_q <= 6'd0;
              if (ones_q == `MDIO_PREAMBLE) st_q <= S_START;
            end
          end
          S_START: begin
            st_q <= bit_in ? S_HDR : S_IDLE;
            cnt_q <= 5'd0;
          end
          S_HDR: begin
            sh_q <= {sh_q[14:0], bit_in};
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == `MDIO_HDR_BITS - 5'd1) begin
              reg_addr <= {sh_q[3:0], bit_in};
              is_rd_q <= (hdr_op == 2'b10);
              cnt_q <= 5'd0;
              // Own address or broadcast zero; bad opcodes drop the frame
              if ((hdr_phy == phy_addr || hdr_phy == 5'h00) && (hdr_op == 2'b10 || hdr_op == 2'b01))
                st_q <= S_TA;
              else
                st_q <= S_IDLE;
            end
          end
          S_TA: begin
            cnt_q <= cnt_q + 5'd1;
            if (is_rd_q && cnt_q == 5'd0) begin
              mdio_oe <= 1'b1;
              mdio_out <= 1'b0;
            end
            if (cnt_q == 5'd1) begin
              cnt_q <= 5'd0;
              st_q <= is_rd_q ? S_RD : S_WR;
              if (is_rd_q) begin
                mdio_out <= rd_data[15];
                sh_q <= {rd_data[14:0], 1'b0};
              end
            end
          end
          S_RD: begin
            cnt_q <= cnt_q + 5'd1;
            mdio_out <= sh_q[15];
            sh_q <= {sh_q[14:0], 1'b0};
            if (cnt_q == `MDIO_DATA_BITS - 5'd1) begin
              mdio_oe <= 1'b0;
              rd_done <= 1'b1;
              st_q <= S_IDLE;
            end
          end
          S_WR: begin
            cnt_q <= cnt_q + 5'd1;
            sh_q <= {sh_q[14:0], bit_in};
            if (cnt_q == `MDIO_DATA_BITS - 5'd1) begin
              wr_data <= {sh_q[14:0], bit_in};
              wr_en <= 1'b1;
              st_q <= S_IDLE;
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: verilog/cable_tester.v */
/*
  Reflectometry cable test sequencer: silences the partner, sends one
  pulse, times the reflection and classifies it.
  Assumes the analog front end flags energy and echoes as async levels.
*/
`timescale 1ns/100ps
`include "phy_diag_regs.vh"

module cable_tester #(
  parameter [15:0] QUIET_CYC = `QUIET_WAIT_CYC,
  parameter [15:0] PULSE_CYC = `TDR_PULSE_CYC,
  parameter [15:0] DIST_DIV = `DIST_STEP_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire start,
  input wire line_energy,
  input wire echo_seen,
  input wire echo_open,
  output reg tdr_pulse,
  output reg silence_req,
  output reg done,
  output reg [1:0] result,
  output reg [8:0] distance
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam T_IDLE = 4'b0001;
  localparam T_QUIET = 4'b0010;
  localparam T_PULSE = 4'b0100;
  localparam T_LISTEN = 4'b1000;

  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg [3:0] st_q;
  reg [15:0] tmr_q;
  reg [8:0] cnt_q;

  // Front-end levels cross into clk_sys
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 3'b000;
      s2_q <= 3'b000;
    end else begin
      s1_q <= {echo_open, echo_seen, line_energy};
      s2_q <= s1_q;
    end
  end

  // Echoes during our own pulse are ignored: they are the pulse itself
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= T_IDLE;
      tmr_q <= 16'h0000;
      cnt_q <= 9'h000;
      tdr_pulse <= 1'b0;
      silence_req <= 1'b0;
      done <= 1'b0;
      result <= `CT_RES_NORMAL;
      distance <= 9'h000;
    end else begin
      done <= 1'b0;
      tmr_q <= tmr_q + 16'h0001;
      case (st_q)
        T_IDLE: begin
          if (start) begin
            silence_req <= 1'b1;
            tmr_q <= 16'h0000;
            st_q <= T_QUIET;
          end
        end
        T_QUIET: begin
          if (tmr_q == QUIET_CYC - 16'h0001) begin
            tmr_q <= 16'h0000;
            if (s2_q[0]) begin
              // Partner still talking: no measurement taken
              result <= `CT_RES_INVALID;
              distance <= 9'h000;
              done <= 1'b1;
              silence_req <= 1'b0;
              st_q <= T_IDLE;
            end else begin
              tdr_pulse <= 1'b1;
              st_q <= T_PULSE;
            end
          end
        end
        T_PULSE: begin
          if (tmr_q == PULSE_CYC - 16'h0001) begin
            tdr_pulse <= 1'b0;
            tmr_q <= 16'h0000;
            cnt_q <= 9'h000;
            st_q <= T_LISTEN;
          end
        end
        T_LISTEN: begin
          if (s2_q[1]) begin
            // Reflection timed into a distance count
            result <= s2_q[2] ? `CT_RES_OPEN : `CT_RES_SHORT;
            distance <= cnt_q;
            done <= 1'b1;
            silence_req <= 1'b0;
            st_q <= T_IDLE;
          end else if (tmr_q == DIST_DIV - 16'h0001) begin
            tmr_q <= 16'h0000;
            if (cnt_q == 9'h1ff) begin
              result <= `CT_RES_NORMAL;
              distance <= 9'h000;
              done <= 1'b1;
              silence_req <= 1'b0;
              st_q <= T_IDLE;
            end else begin
              cnt_q <= cnt_q + 9'h001;
            end
          end
        end
        default: begin
          st_q <= T_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: verification/mdio_host_model.sv */
/* Management host model: sends whole read and write frames.
   Assumes a pull-up on the data line and device address 1. */
`timescale 1ns/100ps
module mdio_host_model (
  output logic mdc,
  output wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic hd = 1'b1;
  logic he = 1'b0;
  // Released line reads high through the pull-up
  assign mdio_in = he ? hd : (mdio_oe ? mdio_out : 1'b1);
  initial mdc = 1'b0;
  // Clock stands low between frames; data moves at the falling edge
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] q);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, rd, !rd, 5'h01, ra, 2'b10, wd};
    for (int i = 0; i < 64; i++) begin
      he = !(rd && i > 45);
      hd = f[63-i];
      #160 mdc = 1'b1;
      q = {q[14:0], mdio_in};
      #160 mdc = 1'b0;
    end
    he = 1'b0;
    #640;
  endtask
endmodule

/* File: verification/phy_diag_checker.sv */
/* Pin checks of the status and diagnostic block.
   Assumes a bind onto the top module; one clock domain. */
`timescale 1ns/100ps
module phy_diag_checker #(
  parameter NIBBLE_MAC = 1
) (
  input wire clk_sys,
  input wire arst_n,
  input wire mdio_out,
  input wire mdio_oe,
  input wire link_100_full,
  input wire remote_loopback,
  input wire local_loopback,
  input wire copper_tx_enable,
  input wire tdr_pulse,
  input wire silence_req,
  input wire nand_tree_strap,
  input wire tree_mode,
  input wire carrier_sense,
  input wire tree_result_pin
);
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Fixed pulse, then the line is left to listen
  sequence pulse_run;
    tdr_pulse [*3] ##1 !tdr_pulse;
  endsequence
  copper_keep_a: assert property ((NIBBLE_MAC != 0 || !local_loopback) |-> copper_tx_enable)
    else $error("copper tx off");
  remote_gate_a: assert property ($past(arst_n) && remote_loopback |-> $past(link_100_full))
    else $error("remote loop without link");
  pulse_width_a: assert property ($rose(tdr_pulse) |-> pulse_run)
    else $error("pulse width");
  quiet_first_a: assert property ($rose(silence_req) |-> !tdr_pulse [*7])
    else $error("pulse before quiet wait");
  pulse_quiet_a: assert property (tdr_pulse |-> silence_req)
    else $error("pulse while partner live");
  tree_pass_a: assert property ($past(arst_n) && !$past(tree_mode) && !tree_mode |->
    tree_result_pin == $past(carrier_sense)) else $error("carrier not passed");
  strap_mode_a: assert property (nand_tree_strap [*4] |-> tree_mode)
    else $error("strap ignored");
  turn_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*7])
    else $error("turnaround bit");
endmodule

/* File: verification/testbench.sv */
/* Self-checking bench of the status and diagnostic block.
   Assumes the host model at device address 1 and a short quiet wait. */
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] int_event = 8'h00;
  logic pair_rx_on_b = 1'b0, link_100_full = 1'b0, line_energy = 1'b0, echo_seen = 1'b0;
  logic echo_open = 1'b0, nand_tree_strap = 1'b0, carrier_sense = 1'b1, c;
  logic [17:0] tree_in = 18'h3ffff;
  wire mdc, mdio_in, mdio_out, mdio_oe, interrupt_request_pin, pair_crossed, local_loopback;
  wire loop_speed_100, copper_tx_enable, remote_loopback, tdr_pulse, silence_req, tree_result_pin, tree_mode;
  logic [15:0] q;
  int miscompares = 0, n_compared = 0;
  // Read flag, index, write data, expected read
  logic [37:0] rows [6] = '{{1'b1, 5'h00, 16'h0, 16'h3100}, {1'b1, 5'h1f, 16'h0, 16'h0},
    {1'b1, 5'h05, 16'h0, 16'h0}, {1'b0, 5'h1b, 16'h01ff, 16'h0}, {1'b1, 5'h1b, 16'h0, 16'h0100},
    {1'b1, 5'h16, 16'h0, 16'h0}};
  // Control word, expected loop and speed
  logic [17:0] lb [4] = '{{16'h4100, 2'b10}, {16'h6100, 2'b11}, {16'h5100, 2'b00}, {16'h4000, 2'b00}};
  // Energy, echo, open, expected start and result
  logic [5:0] ct [4] = '{6'b100011, 6'b011001, 6'b010010, 6'b000000};

  always #20 clk_sys = ~clk_sys;
  mdio_host_model host (.mdc, .mdio_in, .mdio_out, .mdio_oe);
  phy_diag_status_control #(.QUIET_CYC(16'd8)) phy_diag_status_control_i (.clk_sys, .arst_n, .mdc, .mdio_in,
    .mdio_out, .mdio_oe, .phy_addr_strap(3'h1), .int_event, .interrupt_request_pin, .pair_rx_on_b, .pair_crossed,
    .link_100_full, .local_loopback, .loop_speed_100, .copper_tx_enable, .remote_loopback, .line_energy,
    .echo_seen, .echo_open, .tdr_pulse, .silence_req, .nand_tree_strap, .tree_in, .carrier_sense,
    .tree_result_pin, .tree_mode);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task acc(input logic r, input logic [4:0] a, input logic [15:0] d);
    host.xfer(r, a, d, q);
    cyc(2);
  endtask
  // One event pulse, then time for the pin to settle
  task ev(input logic [7:0] e);
    @(negedge clk_sys) int_event = e;
    @(negedge clk_sys) int_event = 8'h00;
    cyc(3);
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    cyc(4);
    arst_n = 1'b1;
    cyc(4);
    foreach (rows[k]) begin
      acc(rows[k][37], rows[k][36:32], rows[k][31:16]);
      if (rows[k][37]) chk("reg", q, rows[k][15:0]);
    end
    // Masked flag stays silent; enabled flag asserts until read
    ev(8'h02);
    chk("irq masked", 16'(interrupt_request_pin), 16'h1);
    ev(8'h01);
    chk("irq low", 16'(interrupt_request_pin), 16'h0);
    acc(1'b1, 5'h1b, 16'h0);
    chk("status", q, 16'h0103);
    chk("irq idle", 16'(interrupt_request_pin), 16'h1);
    acc(1'b1, 5'h1b, 16'h0);
    chk("status clr", q, 16'h0100);
    acc(1'b0, 5'h1f, 16'h0200);
    chk("irq pol", 16'(interrupt_request_pin), 16'h0);
    ev(8'h01);
    chk("irq high", 16'(interrupt_request_pin), 16'h1);
    pair_rx_on_b = 1'b1;
    cyc(4);
    chk("auto x", 16'(pair_crossed), 16'h1);
    acc(1'b0, 5'h1f, 16'h2000);
    chk("mdi", 16'(pair_crossed), 16'h0);
    acc(1'b0, 5'h1f, 16'h6000);
    chk("mdix", 16'(pair_crossed), 16'h1);
    foreach (lb[k]) begin
      acc(1'b0, 5'h00, lb[k][17:2]);
      chk("loop", 16'({local_loopback, loop_speed_100, copper_tx_enable}), 16'({lb[k][1:0], 1'b1}));
    end
    link_100_full = 1'b1;
    acc(1'b0, 5'h1f, 16'h2004);
    chk("remote", 16'(remote_loopback), 16'h1);
    link_100_full = 1'b0;
    cyc(2);
    chk("remote off", 16'(remote_loopback), 16'h0);
    acc(1'b0, 5'h1f, 16'h2000);
    // Cable test per outcome, polling the self-clearing start bit
    foreach (ct[k]) begin
      {line_energy, echo_seen, echo_open} = ct[k][5:3];
      acc(1'b0, 5'h1d, 16'h8000);
      for (int n = 0; n < 20 && q[15]; n++) acc(1'b1, 5'h1d, 16'h0);
      if (q[15]) begin
        miscompares++;
        end_sim;
      end
      chk("cable", q, {ct[k][2:0], 13'h0});
    end
    carrier_sense = 1'b0;
    cyc(2);
    chk("carrier", 16'(tree_result_pin), 16'h0);
    nand_tree_strap = 1'b1;
    cyc(5);
    nand_tree_strap = 1'b0;
    acc(1'b0, 5'h16, 16'h0020);
    chk("tree mode", 16'(tree_mode), 16'h1);
    // Walk the chain low one pin at a time
    for (int i = 0; i <= 18; i++) begin
      c = 1'b1;
      for (int j = 0; j < 18; j++) c = ~(tree_in[j] & c);
      cyc(4);
      chk("tree", 16'(tree_result_pin), 16'(c));
      if (i < 18) tree_in[i] = 1'b0;
    end
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(4);
    chk("rst pins", 16'({interrupt_request_pin, tree_mode}), 16'h2);
    acc(1'b1, 5'h00, 16'h0);
    chk("rst reg", q, 16'h3100);
    end_sim;
  end
endmodule

bind phy_diag_status_control phy_diag_checker #(.NIBBLE_MAC(NIBBLE_MAC)) phy_diag_checker_i (.clk_sys, .arst_n,
  .mdio_out, .mdio_oe, .link_100_full, .remote_loopback, .local_loopback, .copper_tx_enable, .tdr_pulse,
  .silence_req, .nand_tree_strap, .tree_mode, .carrier_sense, .tree_result_pin);
